// ==== tb/wdpd_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module wdpd_top_tb;
  localparam int BASE = 2;

  logic       ref_clk        = 1'b0;
  logic       arst_n         = 1'b0;
  logic       clk_en         = 1'b1;
  logic       slow_osc_clock = 1'b0;
  logic       wd_enable      = 1'b0;
  logic       wd_restart     = 1'b0;
  logic [1:0] div_sel        = 2'h0;
  logic [3:0] code_sel       = 4'h0;
  logic       early_warning;
  logic       wd_timeout;
  logic       wd_counter_clock;
  logic       reserved_select;
  logic       wd_active;
  int         n_fail      = 0;
  int         comparisons = 0;
  int         n_clk       = 0;
  int         n_ew        = 0;
  int         ew_at       = 0;
  int         to_at       = 0;

  // 200 MHz reference clock
  always #2.5 ref_clk = ~ref_clk;

  wdpd_top #(.BASE_CYCLES(BASE)) wdpd_top_inst (
    .ref_clk             (ref_clk),
    .arst_n              (arst_n),
    .clk_en              (clk_en),
    .slow_osc_clock      (slow_osc_clock),
    .wd_enable           (wd_enable),
    .wd_restart          (wd_restart),
    .div_sel             (div_sel),
    .timeout_select_bit3 (code_sel[3]),
    .timeout_select_bit2 (code_sel[2]),
    .timeout_select_bit1 (code_sel[1]),
    .timeout_select_bit0 (code_sel[0]),
    .early_warning       (early_warning),
    .wd_timeout          (wd_timeout),
    .wd_counter_clock    (wd_counter_clock),
    .reserved_select     (reserved_select),
    .wd_active           (wd_active)
  );

  // event monitor, samples settled outputs just after each rising edge
  always @(posedge ref_clk) begin
    #1;
    if (wd_counter_clock === 1'b1) n_clk = n_clk + 1;
    if (early_warning === 1'b1) begin
      ew_at = n_clk;
      n_ew  = n_ew + 1;
    end
    if (wd_timeout === 1'b1) to_at = n_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t %s: seen %0d expected %0d", $time, msg, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // full oscillator periods, ten reference cycles each, then a settle gap
  task automatic osc(input int n);
    repeat (n) begin
      slow_osc_clock = 1'b1;
      repeat (5) @(negedge ref_clk);
      slow_osc_clock = 1'b0;
      repeat (5) @(negedge ref_clk);
    end
    repeat (4) @(negedge ref_clk);
  endtask : osc

  // idle, program settings, enable and wait for the active flag
  task automatic start(input logic [1:0] sel, input logic [3:0] code);
    int i;
    @(negedge ref_clk);
    wd_enable = 1'b0;
    div_sel   = sel;
    code_sel  = code;
    repeat (3) @(negedge ref_clk);
    wd_enable  = 1'b1;
    wd_restart = 1'b1;
    @(negedge ref_clk);
    wd_restart = 1'b0;
    for (i = 0; i < 10 && wd_active !== 1'b1; i++) @(negedge ref_clk);
    if (wd_active !== 1'b1) begin
      check(1'b0, 1'b1, "watchdog never became active");
      end_of_test();
    end
    n_clk = 0;
    n_ew  = 0;
    ew_at = 0;
    to_at = 0;
  endtask : start

  // one oscillator short of three counter clocks, then the last one
  task automatic div_run(input logic [1:0] sel, input int ratio, output int a, output int b);
    start(sel, 4'h3);
    osc(3 * ratio - 1);
    a = n_clk;
    osc(1);
    b = n_clk;
  endtask : div_run

  task automatic test_div3();
    int a, b;
    div_run(2'h1, 3, a, b);
    check(a, 2, "divide by three early");
    check(b, 3, "divide by three count");
  endtask : test_div3

  task automatic test_div5();
    int a, b;
    div_run(2'h2, 5, a, b);
    check(a, 2, "divide by five early");
    check(b, 3, "divide by five count");
  endtask : test_div5

  task automatic test_div7();
    int a, b;
    div_run(2'h3, 7, a, b);
    check(a, 2, "divide by seven early");
    check(b, 3, "divide by seven count");
  endtask : test_div7

  // every valid code, undivided clock for speed
  task automatic test_prescale();
    int c;
    for (c = 0; c < 10; c++) begin
      start(2'h0, c[3:0]);
      osc(2 * (BASE << c));
      check(ew_at, BASE << c, "early warning position");
      check(n_ew, 1, "early warning count");
      check(to_at, 2 * (BASE << c), "final time-out position");
    end
  endtask : test_prescale

  // reserved code raises the flag and holds off all events
  task automatic test_reserved();
    start(2'h0, 4'hA);
    check(reserved_select, 1'b1, "reserved flag");
    osc(8);
    check(n_ew + to_at, 0, "events on reserved code");
    start(2'h0, 4'h9);
    check(reserved_select, 1'b0, "reserved flag clear");
  endtask : test_reserved

  // clock enable low freezes counting and oscillator sampling
  task automatic test_freeze();
    start(2'h0, 4'h0);
    osc(BASE - 1);
    clk_en = 1'b0;
    osc(3);
    clk_en = 1'b1;
    check(n_clk, BASE - 1, "counter clocks while frozen");
    check(n_ew, 0, "early warning while frozen");
    osc(1);
    check(ew_at, BASE, "early warning after freeze");
  endtask : test_freeze

  // restart mid-interval begins the first interval again
  task automatic test_restart();
    start(2'h0, 4'h1);
    osc(2 * BASE - 1);
    wd_restart = 1'b1;
    @(negedge ref_clk);
    wd_restart = 1'b0;
    osc(2 * BASE - 1);
    check(n_ew, 0, "early warning despite restart");
    osc(1);
    check(ew_at, 4 * BASE - 1, "early warning after restart");
  endtask : test_restart

  initial begin
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    check(wd_active, 1'b0, "idle after reset");
    test_div3();
    test_div5();
    test_div7();
    test_prescale();
    test_freeze();
    test_restart();
    test_reserved();
    end_of_test();
  end
endmodule : wdpd_top_tb

`default_nettype wire

// ==== verilog/wdpd_clk_div.sv ====
`timescale 1ns/1ps
`default_nettype none

module wdpd_clk_div (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  // control
  input  wire logic       osc_tick,
  input  wire logic [1:0] div_sel,
  // divided tick
  output logic            wd_tick
);

  wdpd_pkg::wdpd_div_st_t st_reg;
  wdpd_pkg::wdpd_div_st_t st_next;

  // ratio for a divider setting
  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    case (sel)
      wdpd_pkg::DIV_SEL_THREE: div_limit = wdpd_pkg::DIV_RATIO_THREE;
      wdpd_pkg::DIV_SEL_FIVE:  div_limit = wdpd_pkg::DIV_RATIO_FIVE;
      wdpd_pkg::DIV_SEL_SEVEN: div_limit = wdpd_pkg::DIV_RATIO_SEVEN;
      default:                 div_limit = 3'h1;
    endcase
  endfunction : div_limit

  // count oscillator ticks, restart on setting change
  always_comb begin
    st_next          = st_reg;
    st_next.tick_reg = 1'b0;
    st_next.sel_reg  = div_sel;
    if (div_sel != st_reg.sel_reg) begin
      st_next.cnt_reg = 3'h0;
    end else if (osc_tick) begin
      if (st_reg.cnt_reg == div_limit(div_sel) - 3'h1) begin
        st_next.cnt_reg  = 3'h0;
        st_next.tick_reg = 1'b1;
      end else begin
        st_next.cnt_reg = st_reg.cnt_reg + 3'h1;
      end
    end
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign wd_tick = st_reg.tick_reg;

  div_five_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && $past(clk_en) && st_reg.tick_reg && st_reg.sel_reg == wdpd_pkg::DIV_SEL_FIVE)
    |-> ($past(st_reg.cnt_reg) == 3'h4 && $past(osc_tick)))
    else $error("divide by five tick out of place");

  div_seven_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && $past(clk_en) && st_reg.tick_reg && st_reg.sel_reg == wdpd_pkg::DIV_SEL_SEVEN)
    |-> ($past(st_reg.cnt_reg) == 3'h6 && $past(osc_tick)))
    else $error("divide by seven tick out of place");

  div_three_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && osc_tick && div_sel == wdpd_pkg::DIV_SEL_THREE
     && st_reg.sel_reg == wdpd_pkg::DIV_SEL_THREE && st_reg.cnt_reg == 3'h2)
    |=> (!clk_en || st_reg.tick_reg))
    else $error("divide by three tick missing");

endmodule : wdpd_clk_div

`default_nettype wire

// ==== verilog/wdpd_pkg.sv ====
package wdpd_pkg;

  // divider setting codes
  localparam logic [1:0] DIV_SEL_NONE  = 2'h0;
  localparam logic [1:0] DIV_SEL_THREE = 2'h1;
  localparam logic [1:0] DIV_SEL_FIVE  = 2'h2;
  localparam logic [1:0] DIV_SEL_SEVEN = 2'h3;

  // division ratios of the slow oscillator
  localparam logic [2:0] DIV_RATIO_THREE = 3'h3;
  localparam logic [2:0] DIV_RATIO_FIVE  = 3'h5;
  localparam logic [2:0] DIV_RATIO_SEVEN = 3'h7;

  // prescale code range and base interval
  localparam int unsigned SEL_W           = 4;
  localparam logic [3:0]  SEL_LAST_VALID  = 4'h9;
  localparam int unsigned WD_BASE_CYCLES  = 2048;
  localparam int unsigned WD_MAX_CYCLES   = 1048576;
  localparam int unsigned WD_CNT_W        = 22;

  // watchdog sequence phases
  typedef enum logic [1:0] {
    WDPD_IDLE,
    WDPD_FIRST,
    WDPD_SECOND
  } wdpd_phase_t;

  // divider state
  typedef struct packed {
    logic [1:0] sel_reg;
    logic [2:0] cnt_reg;
    logic       tick_reg;
  } wdpd_div_st_t;

  // oscillator sampling chain
  typedef struct packed {
    logic s1_reg;
    logic s2_reg;
    logic prev_reg;
    logic tick_reg;
  } wdpd_sync_t;

  // watchdog outputs
  typedef struct packed {
    logic early_reg;
    logic timeout_reg;
    logic wd_clk_reg;
    logic reserved_reg;
    logic active_reg;
  } wdpd_out_t;

  // top state
  typedef struct packed {
    wdpd_sync_t             sync;
    wdpd_phase_t            phase_reg;
    logic [WD_CNT_W-1:0]    cnt_reg;
    logic [SEL_W-1:0]       code_reg;
    wdpd_out_t              out;
  } wdpd_st_t;

endpackage : wdpd_pkg

// ==== verilog/wdpd_top.sv ====
// Behaviour
// - With divider setting two the watchdog counter advances once per five slow oscillator cycles.
// - With divider setting three the watchdog counter advances once per seven slow oscillator cycles.
// - Prescale codes 0 to 9 give a first time-out after 2048 counter clocks, doubling per step to 1048576.
// - The early warning fires at the first time-out and the final time-out follows one equal interval later.
// - With divider setting one the watchdog counter advances once per three slow oscillator cycles.
`timescale 1ns/1ps
`default_nettype none

module wdpd_top #(
  parameter int unsigned BASE_CYCLES = wdpd_pkg::WD_BASE_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  // slow oscillator pin
  input  wire logic       slow_osc_clock,
  // control from software
  input  wire logic       wd_enable,
  input  wire logic       wd_restart,
  input  wire logic [1:0] div_sel,
  input  wire logic       timeout_select_bit3,
  input  wire logic       timeout_select_bit2,
  input  wire logic       timeout_select_bit1,
  input  wire logic       timeout_select_bit0,
  // watchdog events and status
  output logic            early_warning,
  output logic            wd_timeout,
  output logic            wd_counter_clock,
  output logic            reserved_select,
  output logic            wd_active
);

  // counter width
  localparam int unsigned CW = wdpd_pkg::WD_CNT_W;

  // registered state and its next value
  wdpd_pkg::wdpd_st_t st_reg;
  wdpd_pkg::wdpd_st_t st_next;

  // decoded controls and counter arithmetic
  logic [3:0] code;
  logic       wd_tick;
  logic       code_bad;
  logic [CW-1:0] interval;
  logic [CW-1:0] cnt_inc;

  // interval in counter clocks for a prescale code
  function automatic logic [CW-1:0] code_interval(input logic [3:0] sel);
    logic [CW-1:0] base;
    base          = CW'(BASE_CYCLES);
    code_interval = base << sel;
  endfunction : code_interval

  // gather the select bits
  assign code     = {timeout_select_bit3, timeout_select_bit2,
                     timeout_select_bit1, timeout_select_bit0};
  assign code_bad = code > wdpd_pkg::SEL_LAST_VALID;
  assign interval = code_interval(code);
  assign cnt_inc  = st_reg.cnt_reg + CW'(1);

  // divider of the sampled oscillator
  wdpd_clk_div wdpd_clk_div_inst (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .osc_tick (st_reg.sync.tick_reg),
    .div_sel  (div_sel),
    .wd_tick  (wd_tick)
  );

  // next-state logic: sampling, counting, phases
  always_comb begin
    st_next = st_reg;

    // two-flop sampling then rising edge detect
    st_next.sync.s1_reg   = slow_osc_clock;
    st_next.sync.s2_reg   = st_reg.sync.s1_reg;
    st_next.sync.prev_reg = st_reg.sync.s2_reg;
    st_next.sync.tick_reg = st_reg.sync.s2_reg & ~st_reg.sync.prev_reg;

    // one-cycle event pulses, then the reserved flag and code copy
    st_next.out.early_reg    = 1'b0;
    st_next.out.timeout_reg  = 1'b0;
    st_next.out.wd_clk_reg   = wd_tick;
    st_next.out.reserved_reg = code_bad;
    st_next.code_reg         = code;

    if (!wd_enable) begin
      st_next.phase_reg = wdpd_pkg::WDPD_IDLE;
      st_next.cnt_reg   = '0;
    end else if (wd_restart || st_reg.phase_reg == wdpd_pkg::WDPD_IDLE) begin
      st_next.phase_reg = wdpd_pkg::WDPD_FIRST;
      st_next.cnt_reg   = '0;
    end else if (code_bad) begin
      // undefined codes hold the counter
      st_next.cnt_reg = st_reg.cnt_reg;
    end else if (wd_tick) begin
      case (st_reg.phase_reg)
        wdpd_pkg::WDPD_FIRST: begin
          if (cnt_inc >= interval) begin
            st_next.cnt_reg       = '0;
            st_next.phase_reg     = wdpd_pkg::WDPD_SECOND;
            st_next.out.early_reg = 1'b1;
          end else begin
            st_next.cnt_reg = cnt_inc;
          end
        end
        wdpd_pkg::WDPD_SECOND: begin
          if (cnt_inc >= interval) begin
            st_next.cnt_reg         = '0;
            st_next.phase_reg       = wdpd_pkg::WDPD_FIRST;
            st_next.out.timeout_reg = 1'b1;
          end else begin
            st_next.cnt_reg = cnt_inc;
          end
        end
        default: begin
          st_next.cnt_reg   = '0;
          st_next.phase_reg = wdpd_pkg::WDPD_IDLE;
        end
      endcase
    end

    st_next.out.active_reg = st_next.phase_reg != wdpd_pkg::WDPD_IDLE;
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign early_warning    = st_reg.out.early_reg;
  assign wd_timeout       = st_reg.out.timeout_reg;
  assign wd_counter_clock = st_reg.out.wd_clk_reg;
  assign reserved_select  = st_reg.out.reserved_reg;
  assign wd_active        = st_reg.out.active_reg;

  // helper: counter clocks since the sequence last began
  logic [CW:0] span_reg;
  logic [CW:0] span_goal;

  assign span_goal = {interval, 1'b0};

  // span counter follows the same gating as the main counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      span_reg <= '0;
    end else if (clk_en) begin
      if (!wd_enable || wd_restart || st_reg.phase_reg == wdpd_pkg::WDPD_IDLE
          || st_reg.out.timeout_reg || code != st_reg.code_reg) begin
        span_reg <= '0;
      end else if (wd_tick && !code_bad) begin
        span_reg <= span_reg + (CW+1)'(1);
      end
    end
  end

  // early warning only on the interval-th counter clock of the first phase
  early_at_interval_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && $past(clk_en) && st_reg.out.early_reg)
    |-> ($past(st_reg.phase_reg) == wdpd_pkg::WDPD_FIRST
         && $past(st_reg.cnt_reg) + CW'(1) >= $past(interval) && $past(wd_tick)))
    else $error("early warning not at the selected interval");

  // two full intervals under one code always end in the final time-out
  final_twice_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && !code_bad && code == st_reg.code_reg
     && span_reg == span_goal)
    |-> st_reg.out.timeout_reg)
    else $error("final time-out not after two intervals");

  // final time-out never later than twice the interval
  final_after_early_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && wd_enable && !wd_restart && !code_bad && st_reg.out.timeout_reg
     && code == st_reg.code_reg)
    |-> span_reg <= span_goal)
    else $error("final time-out later than twice the interval");

  // reserved codes raise no events
  reserved_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && code_bad && wd_enable && !wd_restart
     && st_reg.phase_reg != wdpd_pkg::WDPD_IDLE)
    |=> (!clk_en || (!st_reg.out.early_reg && !st_reg.out.timeout_reg)))
    else $error("event raised under reserved prescale code");

  // counter clock output mirrors the divider tick
  clk_mirror_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(clk_en)
    |-> wd_counter_clock == $past(wd_tick))
    else $error("counter clock output out of step with divider");

  // reserved flag follows the prescale code
  reserved_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(clk_en)
    |-> reserved_select == ($past(code) > wdpd_pkg::SEL_LAST_VALID))
    else $error("reserved flag does not follow the code");

  // early warning hands over to the second interval from zero
  early_handover_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_reg.out.early_reg
    |-> (st_reg.phase_reg == wdpd_pkg::WDPD_SECOND && st_reg.cnt_reg == '0))
    else $error("second interval not started at early warning");

  // disabling returns to idle without events
  disable_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (clk_en && !wd_enable)
    |=> (!wd_active && !early_warning && !wd_timeout))
    else $error("watchdog not idle after disable");

  // clock enable low holds every state bit
  frozen_state_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !clk_en
    |=> $stable(st_reg))
    else $error("state moved while clock enable low");

endmodule : wdpd_top

`default_nettype wire
